// *** verilog/ffr_defs.vh ***
// constants for the fault enable and flag register bank
// included by ffr_fault_regs.v; definitions only
`ifndef FFR_DEFS_VH
`define FFR_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FFR_ADDR_UNLOCK 6'h01
`define FFR_ADDR_CONFIG 6'h02
`define FFR_ADDR_PIN_LO 6'h04
`define FFR_ADDR_PIN_HI 6'h05
`define FFR_ADDR_SD_LO 6'h06
`define FFR_ADDR_SD_HI 6'h07
`define FFR_ADDR_FLAGS 6'h08

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FFR_CFG_STICKY_BIT 7
`define FFR_BIT_MOTOR_OC 7
`define FFR_BIT_REG_OC 6
`define FFR_BIT_REG_OV 5
`define FFR_BIT_CORE_OV 4
`define FFR_BIT_PUMP_OV 3
`define FFR_BIT_PUMP_UV 2
`define FFR_BIT_BATT_OV 1
`define FFR_BIT_BATT_UV 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FFR_RST_MASK_LO 8'hFF
`define FFR_RST_MASK_HI 1'h1
`define FFR_RST_FLAGS 8'h00
`define FFR_RST_STICKY 1'h0
`define FFR_RST_UNLOCK 4'h0

// ----------------------------------------------------------------------
// unlock key sequence
// ----------------------------------------------------------------------
`define FFR_KEY_FIRST 4'h5
`define FFR_KEY_SECOND 4'h8
`define FFR_KEY_THIRD 4'h7
`define FFR_KEY_LOCK 4'h0

`endif

// *** verilog/ffr_fault_regs.v ***
// fault pin / driver shutdown enable masks and the supply fault flag register
// assumes a decoded register access port from the serial front end on CLK_SYS,
// and raw fault condition levels from analog detectors (asynchronous)
//
// Overview of operation
// - eight fault pin enable bits at 0x04, one per supply flag, reset to one
// - a set flag with pin enable clear does not pull the fault pin low
// - a set flag with pin enable set drives the fault pin low
// - overtemp pin enable is bit 0 at 0x05, resets one, bits 7:1 read zero
// - eight driver shutdown enable bits at 0x06 matching flag positions, reset one
// - a set flag with shutdown enable set turns off all gate drivers
// - a set flag with shutdown enable clear leaves the gate drivers running
// - overtemp shutdown enable is bit 0 at 0x07, resets one, bits 7:1 read zero
// - flag register 0x08 resets zero, bits motor oc down to battery uv
// - in sticky mode an event sets its flag, which holds until cleared
// - in sticky mode writing one clears a flag, writing zero leaves it
// - in live mode flags show present conditions and writes do nothing
// - sticky mode select is bit 7 of config 0x02, reset zero
// - masks writable only when unlocked by keys 5, 8, 7; key 0 relocks
// - reserved bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "ffr_defs.vh"

module ffr_fault_regs #(
    parameter NUM_SUPPLY = 8
) (
    input wire CLK_SYS,
    input wire RST,
    input wire REG_WR,
    input wire REG_RD,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    output reg REG_RVALID,
    input wire [NUM_SUPPLY-1:0] SUPPLY_FAULT_COND,
    input wire OVERTEMP_COND,
    output reg FAULT_N,
    output reg DRIVER_DISABLE,
    output reg UNLOCKED
);

    // ------------------------------------------------------------------
    // unlock sequencer states
    // ------------------------------------------------------------------
    localparam [1:0] ST_LOCKED = 2'h0;
    localparam [1:0] ST_KEY1 = 2'h1;
    localparam [1:0] ST_KEY2 = 2'h2;
    localparam [1:0] ST_OPEN = 2'h3;

    reg [NUM_SUPPLY-1:0] cond_meta_reg;
    reg [NUM_SUPPLY-1:0] cond_sync_reg;
    reg ot_meta_reg;
    reg ot_sync_reg;
    reg [NUM_SUPPLY-1:0] pin_mask_lo_reg;
    reg pin_mask_hi_reg;
    reg [NUM_SUPPLY-1:0] sd_mask_lo_reg;
    reg sd_mask_hi_reg;
    reg [NUM_SUPPLY-1:0] flags_reg;
    reg [NUM_SUPPLY-1:0] flags_next;
    reg sticky_reg;
    reg [3:0] unlock_val_reg;
    reg [1:0] lock_state_reg;
    reg [1:0] lock_state_next;
    reg [7:0] rdata_next;

    // address decode shared by the write qualifiers
    function addr_hit;
        input [5:0] addr;
        input [5:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // only the low nibble of a key write is compared; upper bits are ignored
    function key_match;
        input [7:0] data;
        input [3:0] key;
        begin
            key_match = (data[3:0] == key);
        end
    endfunction

    // write qualifiers; mask writes need the open state, flag clears do not
    wire wr_unlock = REG_WR && addr_hit(REG_ADDR, `FFR_ADDR_UNLOCK);
    wire wr_open = REG_WR && (lock_state_reg == ST_OPEN);
    wire wr_flags = REG_WR && addr_hit(REG_ADDR, `FFR_ADDR_FLAGS);
    wire [NUM_SUPPLY:0] all_flags = {ot_sync_reg, flags_reg};
    wire [NUM_SUPPLY:0] pin_en = {pin_mask_hi_reg, pin_mask_lo_reg};
    wire [NUM_SUPPLY:0] sd_en = {sd_mask_hi_reg, sd_mask_lo_reg};

    // widen a one-bit enable to a byte with reserved bits zero
    function [7:0] low_bit_only;
        input b;
        begin
            low_bit_only = {7'h00, b};
        end
    endfunction

    // ------------------------------------------------------------------
    // condition synchronisers
    // ------------------------------------------------------------------
    // detector outputs are asynchronous, so two stages before any logic
    always @(posedge CLK_SYS) begin
        if (RST) begin
            cond_meta_reg <= {NUM_SUPPLY{1'b0}};
            cond_sync_reg <= {NUM_SUPPLY{1'b0}};
            ot_meta_reg <= 1'b0;
            ot_sync_reg <= 1'b0;
        end else begin
            cond_meta_reg <= SUPPLY_FAULT_COND;
            cond_sync_reg <= cond_meta_reg;
            ot_meta_reg <= OVERTEMP_COND;
            ot_sync_reg <= ot_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // unlock key sequencer
    // ------------------------------------------------------------------
    // a wrong key mid sequence restarts it; once open only key 0 relocks
    always @* begin
        lock_state_next = lock_state_reg;
        if (wr_unlock) begin
            case (lock_state_reg)
                ST_LOCKED: begin
                    if (key_match(REG_WDATA, `FFR_KEY_FIRST)) begin
                        lock_state_next = ST_KEY1;
                    end else begin
                        lock_state_next = ST_LOCKED;
                    end
                end
                ST_KEY1: begin
                    if (key_match(REG_WDATA, `FFR_KEY_SECOND)) begin
                        lock_state_next = ST_KEY2;
                    end else if (key_match(REG_WDATA, `FFR_KEY_FIRST)) begin
                        lock_state_next = ST_KEY1;
                    end else begin
                        lock_state_next = ST_LOCKED;
                    end
                end
                ST_KEY2: begin
                    if (key_match(REG_WDATA, `FFR_KEY_THIRD)) begin
                        lock_state_next = ST_OPEN;
                    end else if (key_match(REG_WDATA, `FFR_KEY_FIRST)) begin
                        lock_state_next = ST_KEY1;
                    end else begin
                        lock_state_next = ST_LOCKED;
                    end
                end
                ST_OPEN: begin
                    if (key_match(REG_WDATA, `FFR_KEY_LOCK)) begin
                        lock_state_next = ST_LOCKED;
                    end
                end
                default: begin
                    lock_state_next = ST_LOCKED;
                end
            endcase
        end
    end

    // the last key written is kept for read back, even a wrong one
    always @(posedge CLK_SYS) begin
        if (RST) begin
            lock_state_reg <= ST_LOCKED;
            unlock_val_reg <= `FFR_RST_UNLOCK;
        end else begin
            lock_state_reg <= lock_state_next;
            if (wr_unlock) begin
                unlock_val_reg <= REG_WDATA[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // enable masks and configuration
    // ------------------------------------------------------------------
    // locked writes are dropped silently; reserved bits have no storage
    always @(posedge CLK_SYS) begin
        if (RST) begin
            pin_mask_lo_reg <= `FFR_RST_MASK_LO;
            pin_mask_hi_reg <= `FFR_RST_MASK_HI;
            sd_mask_lo_reg <= `FFR_RST_MASK_LO;
            sd_mask_hi_reg <= `FFR_RST_MASK_HI;
            sticky_reg <= `FFR_RST_STICKY;
        end else if (wr_open) begin
            case (REG_ADDR)
                `FFR_ADDR_PIN_LO: begin
                    pin_mask_lo_reg <= REG_WDATA[NUM_SUPPLY-1:0];
                end
                `FFR_ADDR_PIN_HI: begin
                    pin_mask_hi_reg <= REG_WDATA[0];
                end
                `FFR_ADDR_SD_LO: begin
                    sd_mask_lo_reg <= REG_WDATA[NUM_SUPPLY-1:0];
                end
                `FFR_ADDR_SD_HI: begin
                    sd_mask_hi_reg <= REG_WDATA[0];
                end
                `FFR_ADDR_CONFIG: begin
                    sticky_reg <= REG_WDATA[`FFR_CFG_STICKY_BIT];
                end
                default: begin
                    sticky_reg <= sticky_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // supply fault flags
    // ------------------------------------------------------------------
    // a condition present in the clearing cycle wins, so no event is lost
    always @* begin
        if (sticky_reg) begin
            flags_next = flags_reg;
            if (wr_flags) begin
                flags_next = flags_reg & ~REG_WDATA[NUM_SUPPLY-1:0];
            end
            flags_next = flags_next | cond_sync_reg;
        end else begin
            flags_next = cond_sync_reg;
        end
    end

    // flag storage; in live mode it trails the synchroniser by one stage
    always @(posedge CLK_SYS) begin
        if (RST) begin
            flags_reg <= `FFR_RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // fault pin and gate driver shutdown
    // ------------------------------------------------------------------
    // registered so both outputs are glitch free at the pins
    always @(posedge CLK_SYS) begin
        if (RST) begin
            FAULT_N <= 1'b1;
            DRIVER_DISABLE <= 1'b0;
            UNLOCKED <= 1'b0;
        end else begin
            FAULT_N <= ~|(all_flags & pin_en);
            DRIVER_DISABLE <= |(all_flags & sd_en);
            UNLOCKED <= (lock_state_next == ST_OPEN);
        end
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    // unmapped addresses and reserved bits fall through to zero
    always @* begin
        rdata_next = 8'h00;
        case (REG_ADDR)
            `FFR_ADDR_UNLOCK: begin
                rdata_next = {4'h0, unlock_val_reg};
            end
            `FFR_ADDR_CONFIG: begin
                rdata_next = {sticky_reg, 7'h00};
            end
            `FFR_ADDR_PIN_LO: begin
                rdata_next = pin_mask_lo_reg;
            end
            `FFR_ADDR_PIN_HI: begin
                rdata_next = low_bit_only(pin_mask_hi_reg);
            end
            `FFR_ADDR_SD_LO: begin
                rdata_next = sd_mask_lo_reg;
            end
            `FFR_ADDR_SD_HI: begin
                rdata_next = low_bit_only(sd_mask_hi_reg);
            end
            `FFR_ADDR_FLAGS: begin
                rdata_next = flags_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // data is held between reads so a slow host may pick it up late
    always @(posedge CLK_SYS) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_next;
            end
        end
    end

endmodule
`default_nettype wire

// *** dv/ffr_fault_regs_properties.sv ***
// port assertions for the fault register bank
// assumes a bind onto ffr_fault_regs, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ffr_fault_regs_properties #(
    parameter NUM_SUPPLY = 8
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic [NUM_SUPPLY-1:0] SUPPLY_FAULT_COND,
    input wire logic OVERTEMP_COND,
    input wire logic FAULT_N,
    input wire logic DRIVER_DISABLE,
    input wire logic UNLOCKED
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [NUM_SUPPLY:0] cond_q;
    logic [3:0] quiet_cnt;
    // cycles since an input moved or a write; outputs may only move shortly after one
    always @(posedge CLK_SYS) begin
        cond_q <= {OVERTEMP_COND, SUPPLY_FAULT_COND};
        if (RST || REG_WR || cond_q != {OVERTEMP_COND, SUPPLY_FAULT_COND})
            quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF)
            quiet_cnt <= quiet_cnt + 4'h1;
    end
    chk_rvalid_once: assert property (REG_RVALID == $past(REG_RD))
        else $error("read valid not one cycle after strobe");
    chk_rdata_hold: assert property (!REG_RVALID |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    chk_reserved_zero: assert property (
        REG_RD && (REG_ADDR == 6'h05 || REG_ADDR == 6'h07) |=> REG_RDATA[7:1] == 7'h00)
        else $error("reserved bits not zero");
    chk_unmapped_zero: assert property (
        REG_RD && REG_ADDR == 6'h00 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_unlock_key: assert property (
        $rose(UNLOCKED) |-> $past(REG_WR) && $past(REG_ADDR) == 6'h01
            && $past(REG_WDATA[3:0]) == 4'h7)
        else $error("unlocked without final key");
    chk_relock_now: assert property (
        REG_WR && REG_ADDR == 6'h01 && REG_WDATA[3:0] == 4'h0 |=> !UNLOCKED)
        else $error("lock key did not relock");
    chk_reset_idle: assert property (
        $fell(RST) |-> FAULT_N && !DRIVER_DISABLE && !UNLOCKED)
        else $error("outputs not idle after reset");
    chk_out_cause: assert property (
        $changed(FAULT_N) || $changed(DRIVER_DISABLE) |-> quiet_cnt <= 4'h6)
        else $error("fault outputs moved without a cause");
    cover property ($rose(UNLOCKED));
    cover property ($fell(FAULT_N));
    cover property ($rose(DRIVER_DISABLE));
endmodule
bind ffr_fault_regs ffr_fault_regs_properties #(.NUM_SUPPLY(NUM_SUPPLY))
    u_ffr_fault_regs_properties (
    .CLK_SYS(CLK_SYS), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .SUPPLY_FAULT_COND(SUPPLY_FAULT_COND), .OVERTEMP_COND(OVERTEMP_COND), .FAULT_N(FAULT_N),
    .DRIVER_DISABLE(DRIVER_DISABLE), .UNLOCKED(UNLOCKED));
`default_nettype wire

// *** dv/ffr_host_model.sv ***
// host side model issuing decoded register accesses
// assumes the same clock as the register bank
`timescale 1ns/1ps
`default_nettype none
module ffr_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output logic wr,
    output logic rd,
    output logic [5:0] addr,
    output logic [7:0] wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
    end
    // one-cycle strobe; lines scrambled afterwards so stale values are never relied on
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // answer taken at the edge after the valid pulse is raised
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = (rvalid === 1'b1) ? rdata : 8'hXX;
    endtask
    // key sequence opening the masks
    task automatic unlock();
        wr_reg(6'h01, 8'h05);
        wr_reg(6'h01, 8'h08);
        wr_reg(6'h01, 8'h07);
    endtask
    // power-up flags are not trusted: clear them before use
    task automatic drop_boot_flags();
        wr_reg(6'h08, 8'hFF);
    endtask
endmodule
`default_nettype wire

// *** dv/ffr_fault_regs_test.sv ***
// self-checking bench for the fault register bank
// assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module ffr_fault_regs_test;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [7:0] cond = 8'h00;
    logic ot = 1'b0;
    wire h_wr, h_rd, rvalid, fault_n, drv_off, unlocked;
    wire [5:0] h_addr;
    wire [7:0] h_wdata, rdata;
    int errors = 0;
    int checks = 0;
    always #20 CLK_SYS = ~CLK_SYS;
    ffr_host_model u_ffr_host_model (.clk(CLK_SYS), .rdata(rdata), .rvalid(rvalid), .wr(h_wr),
        .rd(h_rd), .addr(h_addr), .wdata(h_wdata));
    ffr_fault_regs #(.NUM_SUPPLY(8)) u_ffr_fault_regs (.CLK_SYS(CLK_SYS), .RST(RST),
        .REG_WR(h_wr), .REG_RD(h_rd), .REG_ADDR(h_addr), .REG_WDATA(h_wdata), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .SUPPLY_FAULT_COND(cond), .OVERTEMP_COND(ot), .FAULT_N(fault_n),
        .DRIVER_DISABLE(drv_off), .UNLOCKED(unlocked));
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_ffr_host_model.rd_reg(a, d);
        cmp8(d, e);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_ffr_host_model.wr_reg(a, d);
    endtask
    // conditions pass two sync stages, so six cycles covers flag and output
    task automatic set_cond(input logic [7:0] c, input logic t);
        @(posedge CLK_SYS);
        cond <= c;
        ot <= t;
        repeat (6) @(posedge CLK_SYS);
    endtask
    // hang guard
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        u_ffr_host_model.drop_boot_flags();
        rd(6'h04, 8'hFF);
        rd(6'h05, 8'h01);
        rd(6'h06, 8'hFF);
        rd(6'h07, 8'h01);
        rd(6'h08, 8'h00);
        rd(6'h02, 8'h00);
        rd(6'h00, 8'h00);
        wr(6'h04, 8'h00);
        rd(6'h04, 8'hFF);
        // live flags follow the condition and ignore writes
        set_cond(8'h01, 1'b0);
        cmp1(fault_n, 1'b0);
        cmp1(drv_off, 1'b1);
        wr(6'h08, 8'hFF);
        rd(6'h08, 8'h01);
        set_cond(8'h00, 1'b0);
        rd(6'h08, 8'h00);
        cmp1(fault_n, 1'b1);
        // unlocked: bit 0 masked both ways, bit 7 pin only, reserved bits dropped
        u_ffr_host_model.unlock();
        @(posedge CLK_SYS);
        cmp1(unlocked, 1'b1);
        wr(6'h04, 8'hFE);
        wr(6'h06, 8'h00);
        wr(6'h05, 8'hFF);
        wr(6'h07, 8'hFE);
        rd(6'h05, 8'h01);
        rd(6'h07, 8'h00);
        set_cond(8'h01, 1'b0);
        cmp1(fault_n, 1'b1);
        cmp1(drv_off, 1'b0);
        set_cond(8'h80, 1'b0);
        cmp1(fault_n, 1'b0);
        cmp1(drv_off, 1'b0);
        set_cond(8'h00, 1'b1);
        cmp1(fault_n, 1'b0);
        cmp1(drv_off, 1'b0);
        wr(6'h07, 8'h01);
        repeat (6) @(posedge CLK_SYS);
        cmp1(drv_off, 1'b1);
        set_cond(8'h00, 1'b0);
        cmp1(fault_n, 1'b1);
        // sticky: a pulse holds, zero keeps, one clears; reserved config bits dropped
        wr(6'h02, 8'hFF);
        rd(6'h02, 8'h80);
        set_cond(8'h04, 1'b0);
        set_cond(8'h00, 1'b0);
        rd(6'h08, 8'h04);
        cmp1(fault_n, 1'b0);
        wr(6'h08, 8'h00);
        rd(6'h08, 8'h04);
        wr(6'h08, 8'h04);
        rd(6'h08, 8'h00);
        // a clear while the condition still stands loses to the set
        set_cond(8'h02, 1'b0);
        wr(6'h08, 8'h02);
        rd(6'h08, 8'h02);
        set_cond(8'h00, 1'b0);
        wr(6'h08, 8'h02);
        rd(6'h08, 8'h00);
        repeat (6) @(posedge CLK_SYS);
        cmp1(fault_n, 1'b1);
        // relock, then a wrong final key keeps it locked
        wr(6'h01, 8'h00);
        wr(6'h04, 8'hFF);
        rd(6'h04, 8'hFE);
        wr(6'h01, 8'h05);
        wr(6'h01, 8'h08);
        wr(6'h01, 8'h06);
        @(posedge CLK_SYS);
        cmp1(unlocked, 1'b0);
        rd(6'h01, 8'h06);
        end_of_test();
    end
endmodule
`default_nettype wire
